// ### tpwm_pkg.sv
// Package for the period timer and system clock PWM block.
// Assumes AXI4-Lite register access with 32-bit data.
`default_nettype none
package tpwm_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_COUNT = 6'h04;
  localparam logic [5:0] OFS_PERIOD = 6'h08;
  localparam logic [5:0] OFS_DUTY_STAGED = 6'h0C;
  localparam logic [5:0] OFS_DUTY_ACTIVE = 6'h10;
  localparam logic [5:0] OFS_PHASE_STAGED = 6'h14;
  localparam logic [5:0] OFS_PHASE_ACTIVE = 6'h18;
  localparam logic [5:0] OFS_FLAGS = 6'h1C;
  localparam logic [5:0] OFS_SYNC_MODE = 6'h20;
  localparam int unsigned CTL_RUN_BIT = 2;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TPWM_STANDALONE, TPWM_MASTER, TPWM_SLAVE} tpwm_sync_mode_t;
  typedef struct packed {
    logic       run;
    logic [1:0] prescale_sel;
  } tpwm_ctrl_t;
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] data;
  } tpwm_wr_t;
endpackage : tpwm_pkg
`default_nettype wire

// ### tpwm_prescaler.sv
// Prescaler: emits a one-cycle tick every 1, 4, 8 or 16 clocks.
// Assumes a synchronous clear from the register logic.
`timescale 1ns/1ps
`default_nettype none
module tpwm_prescaler #(
  parameter int unsigned CNT_W = 4
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;
  always_comb begin
    case (sel_i)
      2'h0:    last = 4'h0;
      2'h1:    last = 4'h3;
      2'h2:    last = 4'h7;
      2'h3:    last = 4'hF;
      default: last = 4'h0;
    endcase
  end
  assign tick_o = run_i && !clear_i && (count >= last);
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || clear_i) begin
      count <= '0;
    end else if (run_i) begin
      count <= tick_o ? '0 : count + 1'b1;
    end
  end
endmodule // tpwm_prescaler
`default_nettype wire

// ### tpwm_axil_slave.sv
// AXI4-Lite slave: one write and one read at a time, byte registers.
// Assumes the register store answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module tpwm_axil_slave (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [5:0] awaddr_i,
  input  wire logic       awvalid_i,
  output logic            awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0] wstrb_i,
  input  wire logic       wvalid_i,
  output logic            wready_o,
  output logic [1:0]      bresp_o,
  output logic            bvalid_o,
  input  wire logic       bready_i,
  input  wire logic [5:0] araddr_i,
  input  wire logic       arvalid_i,
  output logic            arready_o,
  output logic [31:0]     rdata_o,
  output logic [1:0]      rresp_o,
  output logic            rvalid_o,
  input  wire logic       rready_i,
  output tpwm_pkg::tpwm_wr_t wr_o,
  output logic [5:0]      rd_addr_o,
  output logic            rd_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_hit_i,
  input  wire logic       wr_hit_i
);
  logic       aw_held;
  logic       w_held;
  logic [5:0] aw_addr;
  logic [7:0] w_data;
  logic       w_lane0;
  wire  do_write = aw_held && w_held && !bvalid_o;
  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o  = !w_held && !bvalid_o;
  assign arready_o = !rvalid_o;
  assign rd_addr_o = araddr_i;
  assign rd_o      = arvalid_i && arready_o;
  assign wr_o.wr   = do_write && w_lane0 && wr_hit_i;
  assign wr_o.addr = aw_addr;
  assign wr_o.data = w_data;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_lane0  <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o  <= tpwm_pkg::RESP_OKAY;
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= tpwm_pkg::RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held  <= 1'b1;
        w_data  <= wdata_i[7:0];
        w_lane0 <= wstrb_i[0];
      end
      if (do_write) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o  <= wr_hit_i ? tpwm_pkg::RESP_OKAY : tpwm_pkg::RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
      if (rd_o) begin
        rvalid_o <= 1'b1;
        rdata_o  <= {24'h000000, rd_data_i};
        rresp_o  <= rd_hit_i ? tpwm_pkg::RESP_OKAY : tpwm_pkg::RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end
endmodule // tpwm_axil_slave
`default_nettype wire

// ### tpwm_top.sv
// Period timer with prescaler driving the converter system clock PWM.
// Assumes AXI4-Lite master on mclk_i; sync pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Counter and period registers are 8 bits
// - Oscillator through prescaler advances counter
// - Prescale select picks 1, 4, 8, 16
// - Count up, wrap to zero after match
// - Match sets the period match flag
// - Counter and period readable and writable anytime
// - Reset: counter 00h, period FFh
// - Run enable starts and halts counting
// - Prescaler cleared by counter or control writes and reset
// - Control write keeps counter value
// - Control bits 7 to 3 read zero
// - Stand-alone PWM is the system clock
// - Gate drive duty capped by limit
// - Master drives system clock on sync pin
// - Slave ORs sync pin with match
// - Slave pulse latches duty and phase
// - Slave start delayed by phase times prescale
// - Period register sets PWM period
// - After match clear counter, latch duty
// - Duty time is staged duty times prescale
// - Staged duty applies after next match
module tpwm_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [5:0]  s_axil_awaddr_i,
  input  wire logic        s_axil_awvalid_i,
  output logic             s_axil_awready_o,
  input  wire logic [31:0] s_axil_wdata_i,
  input  wire logic [3:0]  s_axil_wstrb_i,
  input  wire logic        s_axil_wvalid_i,
  output logic             s_axil_wready_o,
  output logic [1:0]       s_axil_bresp_o,
  output logic             s_axil_bvalid_o,
  input  wire logic        s_axil_bready_i,
  input  wire logic [5:0]  s_axil_araddr_i,
  input  wire logic        s_axil_arvalid_i,
  output logic             s_axil_arready_o,
  output logic [31:0]      s_axil_rdata_o,
  output logic [1:0]       s_axil_rresp_o,
  output logic             s_axil_rvalid_o,
  input  wire logic        s_axil_rready_i,
  input  wire logic        sync_clock_pin_i,
  output logic             sync_clock_pin_o,
  output logic             sync_clock_pin_oe_o,
  input  wire logic        loop_drive_req_i,
  output logic             system_clock_o,
  output logic             high_side_gate_drive_o,
  output logic             low_side_gate_drive_o,
  output logic             period_match_flag_o
);
  tpwm_pkg::tpwm_ctrl_t      ctrl;
  tpwm_pkg::tpwm_sync_mode_t sync_mode;
  tpwm_pkg::tpwm_wr_t        wr;
  logic [7:0] period_timer_count;
  logic [7:0] period_match_value;
  logic [7:0] duty_limit_staged;
  logic [7:0] duty_limit_active;
  logic [7:0] phase_shift_staged;
  logic [7:0] phase_shift_active;
  logic       period_match_flag;
  logic       pwm_level;
  logic [2:0] sync_sr;
  logic       sync_level;
  logic       or_prev;
  logic [7:0] phase_cnt;
  logic       phase_wait;
  logic       tick;
  logic [5:0] rd_addr;
  logic       rd;
  logic [7:0] rd_data;
  logic       rd_hit;
  logic       wr_hit;

  wire is_slave   = (sync_mode == tpwm_pkg::TPWM_SLAVE);
  wire wr_ctrl    = wr.wr && (wr.addr == tpwm_pkg::OFS_CONTROL);
  wire wr_count   = wr.wr && (wr.addr == tpwm_pkg::OFS_COUNT);
  wire wr_period  = wr.wr && (wr.addr == tpwm_pkg::OFS_PERIOD);
  wire wr_duty    = wr.wr && (wr.addr == tpwm_pkg::OFS_DUTY_STAGED);
  wire wr_phase   = wr.wr && (wr.addr == tpwm_pkg::OFS_PHASE_STAGED);
  wire wr_flags   = wr.wr && (wr.addr == tpwm_pkg::OFS_FLAGS);
  wire wr_mode    = wr.wr && (wr.addr == tpwm_pkg::OFS_SYNC_MODE);
  wire presc_clr  = wr_count || wr_ctrl;
  wire match      = (period_timer_count == period_match_value);
  wire wrap       = tick && match;
  // Slave: external clock ORed with local match, rising edge latches
  wire or_sig     = sync_level || match;
  wire or_pulse   = is_slave && or_sig && !or_prev;
  // Slave holds off the counter during the phase delay
  wire run_tick   = tick && !(is_slave && phase_wait);
  wire run_wrap   = run_tick && match;

  tpwm_prescaler #(
    .CNT_W (4)
  ) u_presc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .clear_i (presc_clr),
    .run_i   (ctrl.run),
    .sel_i   (ctrl.prescale_sel),
    .tick_o  (tick)
  );

  tpwm_axil_slave u_bus (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .awaddr_i  (s_axil_awaddr_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .bresp_o   (s_axil_bresp_o),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .araddr_i  (s_axil_araddr_i),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .wr_o      (wr),
    .rd_addr_o (rd_addr),
    .rd_o      (rd),
    .rd_data_i (rd_data),
    .rd_hit_i  (rd_hit),
    .wr_hit_i  (wr_hit)
  );

  // Write decode: active duty and phase are read only
  assign wr_hit = (wr.addr == tpwm_pkg::OFS_CONTROL) || (wr.addr == tpwm_pkg::OFS_COUNT)
               || (wr.addr == tpwm_pkg::OFS_PERIOD) || (wr.addr == tpwm_pkg::OFS_DUTY_STAGED)
               || (wr.addr == tpwm_pkg::OFS_PHASE_STAGED) || (wr.addr == tpwm_pkg::OFS_FLAGS)
               || (wr.addr == tpwm_pkg::OFS_SYNC_MODE);

  // Read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 8'h00;
    case (rd_addr)
      tpwm_pkg::OFS_CONTROL:      rd_data = {5'h00, ctrl.run, ctrl.prescale_sel};
      tpwm_pkg::OFS_COUNT:        rd_data = period_timer_count;
      tpwm_pkg::OFS_PERIOD:       rd_data = period_match_value;
      tpwm_pkg::OFS_DUTY_STAGED:  rd_data = duty_limit_staged;
      tpwm_pkg::OFS_DUTY_ACTIVE:  rd_data = duty_limit_active;
      tpwm_pkg::OFS_PHASE_STAGED: rd_data = phase_shift_staged;
      tpwm_pkg::OFS_PHASE_ACTIVE: rd_data = phase_shift_active;
      tpwm_pkg::OFS_FLAGS:        rd_data = {7'h00, period_match_flag};
      tpwm_pkg::OFS_SYNC_MODE:    rd_data = {6'h00, sync_mode};
      default: begin
        rd_hit  = 1'b0;
        rd_data = 8'h00;
      end
    endcase
  end

  // Control, staged values and mode
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl               <= '0;
      sync_mode          <= tpwm_pkg::TPWM_STANDALONE;
      period_match_value <= tpwm_pkg::PERIOD_RESET;
      duty_limit_staged  <= tpwm_pkg::DUTY_RESET;
      phase_shift_staged <= tpwm_pkg::PHASE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl.run          <= wr.data[tpwm_pkg::CTL_RUN_BIT];
        ctrl.prescale_sel <= wr.data[1:0];
      end
      if (wr_mode) begin
        case (wr.data[1:0])
          2'h1:    sync_mode <= tpwm_pkg::TPWM_MASTER;
          2'h2:    sync_mode <= tpwm_pkg::TPWM_SLAVE;
          default: sync_mode <= tpwm_pkg::TPWM_STANDALONE;
        endcase
      end
      if (wr_period) begin
        period_match_value <= wr.data;
      end
      if (wr_duty) begin
        duty_limit_staged <= wr.data;
      end
      if (wr_phase) begin
        phase_shift_staged <= wr.data;
      end
    end
  end

  // Counter; control write leaves it alone
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      period_timer_count <= tpwm_pkg::COUNT_RESET;
    end else if (wr_count) begin
      period_timer_count <= wr.data;
    end else if (run_wrap) begin
      period_timer_count <= 8'h00;
    end else if (run_tick) begin
      period_timer_count <= period_timer_count + 8'h01;
    end
  end

  // Match flag: set wins over software clear (write 1 to clear)
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      period_match_flag <= 1'b0;
    end else if (match && ctrl.run) begin
      period_match_flag <= 1'b1;
    end else if (wr_flags && wr.data[0]) begin
      period_match_flag <= 1'b0;
    end
  end

  // Active duty and phase latching
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      duty_limit_active  <= tpwm_pkg::DUTY_RESET;
      phase_shift_active <= tpwm_pkg::PHASE_RESET;
    end else if (or_pulse) begin
      duty_limit_active  <= duty_limit_staged;
      phase_shift_active <= phase_shift_staged;
    end else if (!is_slave && run_wrap) begin
      duty_limit_active  <= duty_limit_staged;
    end
  end

  // Sync pin synchroniser and slave phase delay
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync_sr    <= 3'h0;
      sync_level <= 1'b0;
      or_prev    <= 1'b0;
      phase_cnt  <= 8'h00;
      phase_wait <= 1'b0;
    end else begin
      sync_sr <= {sync_sr[1:0], sync_clock_pin_i};
      if (sync_sr[2] == sync_sr[1]) begin
        sync_level <= sync_sr[2];
      end
      or_prev <= or_sig;
      if (or_pulse && sync_level && (phase_shift_staged != 8'h00)) begin
        phase_wait <= 1'b1;
        phase_cnt  <= phase_shift_staged;
      end else if (phase_wait && tick) begin
        phase_cnt  <= phase_cnt - 8'h01;
        phase_wait <= (phase_cnt != 8'h01);
      end
    end
  end

  // PWM: high from restart, low once counter reaches active duty
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pwm_level <= 1'b0;
    end else if (!ctrl.run || (is_slave && phase_wait)) begin
      pwm_level <= 1'b0;
    end else if (run_wrap) begin
      pwm_level <= (duty_limit_staged != 8'h00);
    end else if (run_tick && (8'(period_timer_count + 8'h01) >= duty_limit_active)) begin
      pwm_level <= 1'b0;
    end
  end

  assign system_clock_o         = pwm_level;
  assign high_side_gate_drive_o = loop_drive_req_i && pwm_level;
  assign low_side_gate_drive_o  = !high_side_gate_drive_o && ctrl.run;
  assign sync_clock_pin_o       = pwm_level;
  assign sync_clock_pin_oe_o    = (sync_mode == tpwm_pkg::TPWM_MASTER);
  assign period_match_flag_o    = period_match_flag;
endmodule // tpwm_top
`default_nettype wire

// ### tpwm_assertions.sv
// Port-level checker for the period timer PWM block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tpwm_assertions (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axil_awvalid_i,
  input wire logic        s_axil_awready_o,
  input wire logic        s_axil_wvalid_i,
  input wire logic        s_axil_wready_o,
  input wire logic        s_axil_bvalid_o,
  input wire logic        s_axil_bready_i,
  input wire logic        s_axil_arvalid_i,
  input wire logic        s_axil_arready_o,
  input wire logic        s_axil_rvalid_o,
  input wire logic        s_axil_rready_i,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic        sync_clock_pin_o,
  input wire logic        sync_clock_pin_oe_o,
  input wire logic        loop_drive_req_i,
  input wire logic        system_clock_o,
  input wire logic        high_side_gate_drive_o,
  input wire logic        low_side_gate_drive_o,
  input wire logic        period_match_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_b_hold; s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axil_rvalid_o && !s_axil_rready_i |=> s_axil_rvalid_o && $stable(s_axil_rdata_o); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_answer;
    s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i && s_axil_wready_o |-> ##[1:3] s_axil_bvalid_o;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write response");
  property p_r_answer; s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o; endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read response");
  property p_w_refuse; s_axil_bvalid_o |-> !s_axil_awready_o && !s_axil_wready_o; endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while response pending");
  property p_high_cap; high_side_gate_drive_o |-> loop_drive_req_i && system_clock_o; endproperty
  a_high_cap: assert property (p_high_cap) else $error("high drive outside duty window");
  property p_gate_excl; not (high_side_gate_drive_o && low_side_gate_drive_o); endproperty
  a_gate_excl: assert property (p_gate_excl) else $error("both gate drives on");
  property p_master_pin; sync_clock_pin_oe_o |-> sync_clock_pin_o == system_clock_o; endproperty
  a_master_pin: assert property (p_master_pin) else $error("sync pin differs from system clock");
  property p_flag_clear; $fell(period_match_flag_o) |-> s_axil_bvalid_o; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("match flag cleared without write");
endmodule // tpwm_assertions
bind tpwm_top tpwm_assertions u_chk (.*);
`default_nettype wire

// ### tpwm_sync_partner.sv
// Far-side converter acting as sync master clock source.
// Assumes the bench resolves the pin with its pull-up.
`timescale 1ns/1ps
`default_nettype none
module tpwm_sync_partner (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [7:0] half_i,
  output logic            clk_o
);
  logic [7:0] cnt;
  // Master clock toggles every half_i+1 cycles while enabled
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !en_i) begin
      cnt <= 8'h00;
      clk_o <= 1'h0;
    end else if (cnt == half_i) begin
      cnt <= 8'h00;
      clk_o <= !clk_o;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // tpwm_sync_partner
`default_nettype wire

// ### test_timer2_pwm_system_clock.sv
// Self-checking bench for the period timer PWM block.
// Assumes the checker is bound and the partner drives the sync pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_timer2_pwm_system_clock;
  logic mclk_i, rst_n_i, s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i, s_axil_arvalid_i;
  logic s_axil_rready_i, sync_clock_pin_i, loop_drive_req_i, pen, pclk;
  logic s_axil_awready_o, s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o, s_axil_rvalid_o;
  logic sync_clock_pin_o, sync_clock_pin_oe_o, system_clock_o;
  logic high_side_gate_drive_o, low_side_gate_drive_o, period_match_flag_o;
  logic [5:0]  s_axil_awaddr_i, s_axil_araddr_i;
  logic [31:0] s_axil_wdata_i, s_axil_rdata_o, seed, rd;
  logic [3:0]  s_axil_wstrb_i;
  logic [1:0]  s_axil_bresp_o, s_axil_rresp_o, rsp;
  logic [7:0]  p, d, a, prev;
  int miscompares, check_count, per, hi;
  tpwm_top uut (.*);
  tpwm_sync_partner u_far (.mclk_i, .rst_n_i, .en_i(pen), .half_i(8'h14), .clk_o(pclk));
  // Pin resolves to pull-up level when nobody drives
  assign sync_clock_pin_i = sync_clock_pin_oe_o ? sync_clock_pin_o : (pen ? pclk : 1'h1);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int div(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 8 : 16;
  endfunction
  task automatic axi(input bit w, input logic [5:0] ad, input logic [7:0] dt);
    int n;
    bit a_r, w_r, r_r, ok;
    @(posedge mclk_i);
    if (w) begin
      s_axil_awaddr_i <= ad;
      s_axil_wdata_i <= {24'h000000, dt};
      s_axil_awvalid_i <= 1'h1;
      s_axil_wvalid_i <= 1'h1;
      s_axil_bready_i <= 1'h1;
    end else begin
      s_axil_araddr_i <= ad;
      s_axil_arvalid_i <= 1'h1;
      s_axil_rready_i <= 1'h1;
    end
    n = 0;
    do begin
      @(negedge mclk_i);
      a_r = s_axil_awready_o;
      w_r = s_axil_wready_o;
      r_r = s_axil_arready_o;
      ok = w ? s_axil_bvalid_o : s_axil_rvalid_o;
      rsp = w ? s_axil_bresp_o : s_axil_rresp_o;
      rd = s_axil_rdata_o;
      @(posedge mclk_i);
      n++;
      if (a_r) s_axil_awvalid_i <= 1'h0;
      if (w_r) s_axil_wvalid_i <= 1'h0;
      if (r_r) s_axil_arvalid_i <= 1'h0;
    end while (!ok && n < 100);
    s_axil_bready_i <= 1'h0;
    s_axil_rready_i <= 1'h0;
    if (n >= 100) miscompares++;
  endtask
  task automatic meas();
    int n;
    n = 0;
    while (system_clock_o !== 1'h0 && n < 2000) begin @(negedge mclk_i); n++; end
    while (system_clock_o !== 1'h1 && n < 2000) begin @(negedge mclk_i); n++; end
    hi = 0;
    while (system_clock_o === 1'h1 && hi < 2000) begin @(negedge mclk_i); hi++; end
    per = hi;
    while (system_clock_o === 1'h0 && per < 4000) begin @(negedge mclk_i); per++; end
  endtask
  task summarize();
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk_i = 1'h0;
    forever #2.5 mclk_i = !mclk_i;
  end
  always @(posedge mclk_i) loop_drive_req_i <= ^rnd();
  initial begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    summarize();
  end
  initial begin
    {rst_n_i, s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i, s_axil_arvalid_i, s_axil_rready_i} = '0;
    {loop_drive_req_i, pen, s_axil_awaddr_i, s_axil_araddr_i, s_axil_wdata_i} = '0;
    s_axil_wstrb_i = 4'hF;
    seed = 32'h00015A23;
    prev = tpwm_pkg::DUTY_RESET;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    axi(0, tpwm_pkg::OFS_COUNT, 8'h00);
    `CHK("count reset", 32'h00, rd)
    axi(0, tpwm_pkg::OFS_PERIOD, 8'h00);
    `CHK("period reset", 32'hFF, rd)
    axi(0, 6'h24, 8'h00);
    `CHK("unmapped resp", tpwm_pkg::RESP_SLVERR, rsp)
    axi(1, tpwm_pkg::OFS_DUTY_ACTIVE, 8'h11);
    `CHK("active duty write resp", tpwm_pkg::RESP_SLVERR, rsp)
    axi(1, tpwm_pkg::OFS_CONTROL, 8'hF8);
    axi(0, tpwm_pkg::OFS_CONTROL, 8'h00);
    `CHK("control upper bits", 32'h00, rd)
    for (int s = 0; s < 4; s++) begin
      p = 8'(3 + rnd() % 8);
      d = 8'(1 + rnd() % (p - 1));
      axi(1, tpwm_pkg::OFS_CONTROL, 8'h00);
      axi(1, tpwm_pkg::OFS_PERIOD, p);
      axi(1, tpwm_pkg::OFS_DUTY_STAGED, d);
      axi(0, tpwm_pkg::OFS_DUTY_ACTIVE, 8'h00);
      `CHK("active before match", {24'h0, prev}, rd)
      axi(1, tpwm_pkg::OFS_COUNT, 8'h00);
      axi(1, tpwm_pkg::OFS_CONTROL, {5'h00, 1'h1, 2'(s)});
      meas();
      meas();
      `CHK("pwm period", (p + 1) * div(2'(s)), per)
      `CHK("pwm high time", d * div(2'(s)), hi)
      axi(0, tpwm_pkg::OFS_DUTY_ACTIVE, 8'h00);
      `CHK("active after match", {24'h0, d}, rd)
      prev = d;
    end
    axi(1, tpwm_pkg::OFS_CONTROL, 8'h03);
    axi(0, tpwm_pkg::OFS_COUNT, 8'h00);
    a = rd[7:0];
    repeat (40) @(posedge mclk_i);
    axi(0, tpwm_pkg::OFS_COUNT, 8'h00);
    `CHK("halted count", {24'h0, a}, rd)
    axi(1, tpwm_pkg::OFS_COUNT, 8'h37);
    axi(1, tpwm_pkg::OFS_CONTROL, 8'h03);
    axi(0, tpwm_pkg::OFS_COUNT, 8'h00);
    `CHK("count after control write", 32'h37, rd)
    axi(0, tpwm_pkg::OFS_CONTROL, 8'h00);
    `CHK("control readback", 32'h03, rd)
    axi(0, tpwm_pkg::OFS_FLAGS, 8'h00);
    `CHK("match flag set", 1'h1, rd[0])
    axi(1, tpwm_pkg::OFS_FLAGS, 8'h01);
    axi(0, tpwm_pkg::OFS_FLAGS, 8'h00);
    `CHK("match flag cleared", 1'h0, rd[0])
    axi(1, tpwm_pkg::OFS_SYNC_MODE, 8'h01);
    axi(1, tpwm_pkg::OFS_CONTROL, 8'h04);
    repeat (50) @(posedge mclk_i);
    `CHK("master pin enable", 1'h1, sync_clock_pin_oe_o)
    axi(1, tpwm_pkg::OFS_CONTROL, 8'h00);
    axi(1, tpwm_pkg::OFS_SYNC_MODE, 8'h02);
    a = 8'(rnd());
    d = 8'(rnd() | 32'h1);
    axi(1, tpwm_pkg::OFS_PHASE_STAGED, a);
    axi(1, tpwm_pkg::OFS_DUTY_STAGED, d);
    pen <= 1'h1;
    repeat (200) @(posedge mclk_i);
    `CHK("slave pin enable", 1'h0, sync_clock_pin_oe_o)
    axi(0, tpwm_pkg::OFS_PHASE_ACTIVE, 8'h00);
    `CHK("slave phase latch", {24'h0, a}, rd)
    axi(0, tpwm_pkg::OFS_DUTY_ACTIVE, 8'h00);
    `CHK("slave duty latch", {24'h0, d}, rd)
    pen <= 1'h0;
    summarize();
  end
endmodule // test_timer2_pwm_system_clock
`default_nettype wire
